// File: dv/hbp_host_model.sv
// host processor side of the parallel port, all pins moved at falling edge
module hbp_host_model (
    input  wire logic       clk_i,
    output logic            cfg_o,
    output logic            sel1_o,
    output logic            sel2_o,
    output logic            wr_dir_o,
    output logic            rd_o,
    output logic            latch_o,
    output logic            sel_n_o,
    output logic            hw4_o,
    output logic [7:0]      addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus, mode pin left high as if floating
    initial begin
        {cfg_o, sel1_o, sel2_o, latch_o, hw4_o} = 5'h10;
        {wr_dir_o, rd_o, sel_n_o} = 3'h7;
        addr_o = 8'h00;
    end
    // mode pin and style code are held steady by the board
    task automatic set_cfg(input logic hw, input logic [1:0] s);
        @(negedge clk_i);
        cfg_o = hw;
        {sel2_o, sel1_o} = s;
    endtask : set_cfg
    // address then strobe; address lines wander once latched
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic dir, input logic nosel);
        @(negedge clk_i);
        addr_o = a;
        latch_o = 1'b1;
        sel_n_o = nosel;
        @(negedge clk_i);
        latch_o = 1'b0;
        repeat (2) @(negedge clk_i);
        addr_o = ~a;
        wr_dir_o = !wr; // low for a write in both styles
        rd_o = (dir || !wr) ? 1'b0 : 1'b1;
    endtask : access
    // strobes and select released together
    task automatic release_bus();
        @(negedge clk_i);
        {wr_dir_o, rd_o, sel_n_o} = 3'h7;
    endtask : release_bus
    // hardware mode: the bus pins become plain selector levels
    task automatic hw_drive(input logic [4:0] v);
        @(negedge clk_i);
        {hw4_o, sel_n_o, latch_o, rd_o, wr_dir_o} = v;
    endtask : hw_drive
endmodule : hbp_host_model

// File: dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hbp_pkg::*;
    logic        clk_i   = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        cfg, s1, s2, wr_dir, rd_strobe, latch, sel_n, hw4, done_pin;
    logic [7:0]  addr, addr_o, a;
    logic        done_o, done_oe_o, host_mode_o, wr_pulse_o, rd_pulse_o;
    hbp_style_e  style_o;
    logic [4:0]  sel_o, v;
    logic [9:0]  exp_q[$];
    logic [9:0]  e;
    integer      errors = 0;
    integer      comparisons = 0;
    integer      seed = 86608;
    integer      n;
    always #2.5 clk_i = ~clk_i;
    // completion pin level: device drives it only while enabled
    assign done_pin = done_oe_o ? done_o : hw4;
    hbp_host_model host (.clk_i(clk_i), .cfg_o(cfg), .sel1_o(s1),
        .sel2_o(s2), .wr_dir_o(wr_dir), .rd_o(rd_strobe), .latch_o(latch),
        .sel_n_o(sel_n), .hw4_o(hw4), .addr_o(addr));
    hbp_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .pin_or_bus_config_i(cfg), .cpu_style_sel1_i(s1),
        .cpu_style_sel2_i(s2), .wr_dir_i(wr_dir),
        .rd_transfer_strobe_i(rd_strobe), .latch_bus_addr_qualifier_i(latch),
        .dev_sel_n_i(sel_n), .done_pin_i(done_pin), .addr_i(addr),
        .done_o(done_o), .done_oe_o(done_oe_o), .style_o(style_o),
        .host_mode_o(host_mode_o), .addr_o(addr_o),
        .wr_pulse_o(wr_pulse_o), .rd_pulse_o(rd_pulse_o),
        .line_setting_sel_o(sel_o));
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    // one access, waiting on completion under a bounded count
    task automatic run(input logic wr, input logic [7:0] ad,
                       input logic dir);
        logic act;
        act = !dir;
        host.access(wr, ad, dir, 1'b0);
        for (n = 0; n < 40 && done_o !== act; n++) @(negedge clk_i);
        check("done active", 16'(done_o), 16'(act));
        check("done enable", 16'(done_oe_o), 16'h0001);
        host.release_bus();
        for (n = 0; n < 12 && done_o === act; n++) @(negedge clk_i);
        check("done inactive", 16'(done_o), 16'(!act));
    endtask : run
    // every pulse must match the oldest note; a stray one meets zero;
    // looked at on the falling edge, where the registered pulse has settled
    always @(negedge clk_i) begin
        if (rst_n_i && (wr_pulse_o === 1'b1 || rd_pulse_o === 1'b1)) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h000;
            check("pulse and address", 16'({wr_pulse_o, rd_pulse_o,
                addr_o}), 16'(e));
        end
    end
    // watchdog: the sequence needs well under 20000 cycles
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
    initial begin
        repeat (6) @(negedge clk_i);
        check("reset outputs", 16'({done_o, done_oe_o, style_o,
            wr_pulse_o, rd_pulse_o, sel_o}), 16'h0000);
        $display("test reset done");
        rst_n_i = 1'b1;
        for (int s = 0; s < 4; s++) begin
            host.set_cfg(1'b0, 2'(s));
            repeat (5) @(negedge clk_i);
            check("host mode", 16'(host_mode_o), 16'h0001);
            check("style", 16'(style_o), 16'(s));
            for (int k = 0; k < 2; k++) begin
                a = 8'($random(seed));
                exp_q.push_back({k == 0, k == 1, a});
                run(k == 0, a, s[0]);
            end
            $display("test style %0d done", s);
        end
        // strobe with select high must be ignored
        host.access(1'b1, 8'hA5, 1'b1, 1'b1);
        repeat (15) @(negedge clk_i);
        check("done idle", 16'(done_o), 16'h0001);
        check("address held", 16'(addr_o), 16'(a));
        host.release_bus();
        $display("test select high done");
        host.set_cfg(1'b1, 2'h0);
        repeat (5) @(negedge clk_i);
        check("hardware mode", 16'(host_mode_o), 16'h0000);
        for (int k = 0; k < 6; k++) begin
            v = 5'($random(seed));
            host.hw_drive(v);
            repeat (5) @(negedge clk_i);
            check("line setting", 16'(sel_o), 16'(v));
        end
        $display("test hardware mode done");
        give_verdict();
    end
endmodule : tb

// File: verilog/hbp_cfg.svh
`ifndef HBP_CFG_SVH
`define HBP_CFG_SVH

// last latency counter value; completion comes this plus two cycles after strobe seen, access latency of the core
`define HBP_ACK_DELAY   3'h2
`define HBP_ADDR_W      8
`define HBP_ADDR_RST    8'h00
`define HBP_SEL_RST     5'h00
`define HBP_STYLE_RST   2'h0
// pin levels the synchroniser holds in reset: mode pin high, strobes and
// select idle high, latch low; zeros here would fake an access at release
`define HBP_PIN_RST     16'h9A00
`endif

// File: verilog/hbp_pkg.sv
package hbp_pkg;
    // bus timing style, upper bit is style select bit two
    typedef enum logic [1:0] {
        HBP_ASYNC_SEP = 2'b00,
        HBP_ASYNC_DIR = 2'b01,
        HBP_SYNC_SEP  = 2'b10,
        HBP_SYNC_DIR  = 2'b11
    } hbp_style_e;
    typedef enum logic [1:0] {
        HBP_IDLE = 2'b00,
        HBP_WAIT = 2'b01,
        HBP_DONE = 2'b10
    } hbp_state_e;
endpackage : hbp_pkg

// File: verilog/hbp_port.sv
`include "hbp_cfg.svh"
module hbp_port (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              pin_or_bus_config_i,
    input  wire logic              cpu_style_sel1_i,
    input  wire logic              cpu_style_sel2_i,
    input  wire logic              wr_dir_i,
    input  wire logic              rd_transfer_strobe_i,
    input  wire logic              latch_bus_addr_qualifier_i,
    input  wire logic              dev_sel_n_i,
    input  wire logic              done_pin_i,
    input  wire logic [7:0]        addr_i,
    output logic                   done_o,
    output logic                   done_oe_o,
    output hbp_pkg::hbp_style_e    style_o,
    output logic                   host_mode_o,
    output logic [7:0]             addr_o,
    output logic                   wr_pulse_o,
    output logic                   rd_pulse_o,
    output logic [4:0]             line_setting_sel_o
);
    import hbp_pkg::*;

    // ************************************************************
    // pin synchronisation
    // ************************************************************
    logic [15:0] raw;
    logic [15:0] s;
    assign raw = {pin_or_bus_config_i, cpu_style_sel2_i, cpu_style_sel1_i,
                  wr_dir_i, rd_transfer_strobe_i,
                  latch_bus_addr_qualifier_i, dev_sel_n_i, done_pin_i,
                  addr_i};

    hbp_sync #(
        .W       (16),
        .RST_VAL (`HBP_PIN_RST)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (raw),
        .q_o     (s)
    );

    logic       mode_s;
    logic [1:0] style_s;
    logic       wr_s;
    logic       rd_s;
    logic       ale_s;
    logic       sel_n_s;
    logic       dpin_s;
    logic [7:0] addr_s;
    assign mode_s  = s[15];
    assign style_s = s[14:13];
    assign wr_s    = s[12];
    assign rd_s    = s[11];
    assign ale_s   = s[10];
    assign sel_n_s = s[9];
    assign dpin_s  = s[8];
    assign addr_s  = s[7:0];

    // selector view of the bus pins, used by hardware mode and its check
    logic [4:0] hw_pins;
    assign hw_pins = {dpin_s, sel_n_s, ale_s, rd_s, wr_s};

    // ************************************************************
    // mode and style
    // ************************************************************
    logic       host;
    logic       dir_style;
    assign host      = ~mode_s;
    assign dir_style = style_s[0];
    assign host_mode_o = host;

    // style register, held in reset until host mode is seen
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            style_o <= hbp_style_e'(`HBP_STYLE_RST);
        end else if (host) begin
            style_o <= hbp_style_e'(style_s);
        end
    end

    // hardware mode: bus pins become line setting selectors
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_setting_sel_o <= `HBP_SEL_RST;
        end else if (!host) begin
            line_setting_sel_o <= hw_pins;
        end
    end

    // ************************************************************
    // address latch
    // ************************************************************
    logic ale_d1_q;
    logic ale_fall;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ale_d1_q <= 1'b0;
        end else begin
            ale_d1_q <= ale_s;
        end
    end
    assign ale_fall = ale_d1_q & ~ale_s;

    // latch on falling edge of latch or qualifier strobe; pins are delayed
    // equally, so the address sampled alongside is the one seen with the latch first low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_o <= `HBP_ADDR_RST;
        end else if (host && !sel_n_s && ale_fall) begin
            addr_o <= addr_s;
        end
    end

    // ************************************************************
    // access state machine
    // ************************************************************
    logic       strobe;
    logic       is_write;
    assign strobe   = dir_style ? ~rd_s : (~rd_s | ~wr_s);
    assign is_write = ~wr_s;  // write or direction pin low

    hbp_state_e state_q;
    logic [2:0] cnt_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= HBP_IDLE;
        end else begin
            unique case (state_q)
                HBP_IDLE: begin
                    if (host && !sel_n_s && strobe) begin
                        state_q <= HBP_WAIT;
                    end
                end
                HBP_WAIT: begin
                    if (sel_n_s || !strobe) begin
                        state_q <= HBP_IDLE;
                    end else if (cnt_q == `HBP_ACK_DELAY) begin
                        state_q <= HBP_DONE;
                    end
                end
                HBP_DONE: begin
                    if (sel_n_s || !strobe || !host) begin
                        state_q <= HBP_IDLE;
                    end
                end
                default: state_q <= HBP_IDLE;
            endcase
        end
    end

    // latency counter runs only while waiting
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 3'h0;
        end else if (state_q == HBP_WAIT) begin
            cnt_q <= cnt_q + 3'h1;
        end else begin
            cnt_q <= 3'h0;
        end
    end

    // one pulse to the core at the start of each access
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pulse_o <= 1'b0;
            rd_pulse_o <= 1'b0;
        end else begin
            wr_pulse_o <= (state_q == HBP_IDLE) && host && !sel_n_s
                          && strobe && is_write;
            rd_pulse_o <= (state_q == HBP_IDLE) && host && !sel_n_s
                          && strobe && !is_write;
        end
    end

    // completion pin: ready high or acknowledge low, driven only while selected in host mode
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o    <= 1'b0;
            done_oe_o <= 1'b0;
        end else begin
            done_oe_o <= host && !sel_n_s;
            if (dir_style) begin
                done_o <= ~(state_q == HBP_DONE);
            end else begin
                done_o <= (state_q == HBP_DONE);
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_access_start;
        state_q == HBP_IDLE && host && !sel_n_s && strobe;
    endsequence

    AST_DONE_IN_TIME: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        s_access_start ##1 (!sel_n_s && strobe)[*4] |-> state_q == HBP_DONE)
        else $error("access did not complete");
    AST_NO_SEL_NO_ACCESS: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        sel_n_s |=> !wr_pulse_o && !rd_pulse_o)
        else $error("access started without select");
    AST_RDY_HIGH: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q == HBP_DONE && !dir_style) |=> done_o)
        else $error("ready not high on completion");
    AST_ACK_LOW: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q == HBP_DONE && dir_style) |=> !done_o)
        else $error("acknowledge not low on completion");
    AST_RELEASE: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (state_q == HBP_DONE && sel_n_s) |=> state_q == HBP_IDLE)
        else $error("completion held after release");
    AST_ADDR_LATCH: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (host && !sel_n_s && ale_fall) |=> addr_o == $past(addr_s))
        else $error("address not latched");
    AST_HW_SEL: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !host |=> line_setting_sel_o == $past(hw_pins))
        else $error("hardware selectors not sampled");
    AST_WR_DIR: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_pulse_o |-> !$past(wr_s))
        else $error("write pulse with direction high");
endmodule : hbp_port

// File: verilog/hbp_sync.sv
// two-flop synchroniser for a bundle of pin levels
module hbp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // idle pin levels, so no false edge follows reset
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : hbp_sync
